// file: rtl/fws_status_poller.sv
`timescale 1ns/1ps
`include "fws_regs.svh"
module fws_status_poller (
  input wire logic pclk, // APB clock, 40 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic [7:0] paddr, // APB address
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction, high for write
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output fws_pkg::fws_pins_t flash_pins, // Flash chip select, output enable, address
  input wire logic [7:0] flash_dq, // Flash data lines, low byte
  input wire logic ready_busy_n_pin // Flash ready/busy line, pulled up
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [7:0] dq_s1_q, dq_s2_q;
  logic rb_s1_q, rb_s2_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      rb_s1_q <= 1'b1;
      rb_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= flash_dq;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= ready_busy_n_pin;
      rb_s2_q <= rb_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // APB slave and control registers
  // ----------------------------------------------------------------
  logic mode_q, mode_d;
  logic [`FWS_ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] exp_q, exp_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic start_wr;
  logic wr_acc;
  logic busy_q, done_q, pass_q, fail_q, setg_q, tmo_q;
  logic [7:0] data_q;

  assign wr_acc = psel && penable && pwrite && pready_q;

  always_comb begin
    mode_d = mode_q;
    addr_d = addr_q;
    exp_d = exp_q;
    prdata_d = prdata_q;
    pslverr_d = pslverr_q;
    pready_d = psel && !penable;
    start_wr = 1'b0;
    if (psel && !penable) begin
      prdata_d = 32'h0000_0000;
      pslverr_d = 1'b0;
      if (paddr == `FWS_OFF_CTRL) begin
        prdata_d[`FWS_CTRL_MODE] = mode_q;
      end else if (paddr == `FWS_OFF_ADDR) begin
        prdata_d[`FWS_ADDR_W-1:0] = addr_q;
      end else if (paddr == `FWS_OFF_EXP) begin
        prdata_d[7:0] = exp_q;
      end else if (paddr == `FWS_OFF_STAT) begin
        prdata_d[`FWS_STAT_BUSY] = busy_q;
        prdata_d[`FWS_STAT_DONE] = done_q;
        prdata_d[`FWS_STAT_PASS] = pass_q;
        prdata_d[`FWS_STAT_FAIL] = fail_q;
        prdata_d[`FWS_STAT_SETG] = setg_q;
        prdata_d[`FWS_STAT_TMO] = tmo_q;
        prdata_d[`FWS_STAT_RDY] = rb_s2_q;
        prdata_d[`FWS_STAT_DATA_LO +: 8] = data_q;
      end else begin
        pslverr_d = 1'b1;
      end
    end
    if (wr_acc) begin
      if (paddr == `FWS_OFF_CTRL) begin
        mode_d = pwdata[`FWS_CTRL_MODE];
        start_wr = pwdata[`FWS_CTRL_START];
      end else if (paddr == `FWS_OFF_ADDR) begin
        addr_d = pwdata[`FWS_ADDR_W-1:0];
      end else if (paddr == `FWS_OFF_EXP) begin
        exp_d = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= 1'b0;
      addr_q <= `FWS_RST_ADDR;
      exp_q <= `FWS_RST_EXP;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      addr_q <= addr_d;
      exp_q <= exp_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // Status read sequencer
  // ----------------------------------------------------------------
  localparam logic [3:0] ACC_LOAD = 4'(`FWS_ACC_CYC + `FWS_SYNC_CYC);
  localparam logic [3:0] GAP_LOAD = 4'(`FWS_GAP_CYC - 1);

  fws_pkg::fws_state_t st_q, st_d;
  fws_pkg::fws_step_t step_q, step_d;
  fws_pkg::fws_pins_t pins_q, pins_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] rd_q, rd_d, first_q, first_d, data_d;
  logic busy_d, done_d, pass_d, fail_d, setg_d, tmo_d;
  logic pol_match;

  assign pol_match = rd_q[`FWS_BIT_POLARITY] == exp_q[`FWS_BIT_POLARITY];

  always_comb begin
    st_d = st_q;
    step_d = step_q;
    pins_d = pins_q;
    cnt_d = cnt_q;
    rd_d = rd_q;
    first_d = first_q;
    data_d = data_q;
    busy_d = busy_q;
    done_d = done_q;
    pass_d = pass_q;
    fail_d = fail_q;
    setg_d = setg_q;
    tmo_d = tmo_q;
    case (st_q)
      fws_pkg::S_IDLE: begin
        if (start_wr) begin
          pins_d.addr = addr_q;
          pins_d.ce_n = 1'b0;
          pins_d.oe_n = 1'b0;
          cnt_d = ACC_LOAD;
          step_d = mode_d ? fws_pkg::K_TOG1 : fws_pkg::K_POLL;
          {busy_d, done_d, pass_d, fail_d, setg_d, tmo_d} = 6'b100000;
          st_d = fws_pkg::S_ACCESS;
        end
      end
      fws_pkg::S_ACCESS: begin
        if (cnt_q == 4'h0) begin
          rd_d = dq_s2_q;
          pins_d.ce_n = 1'b1;
          pins_d.oe_n = 1'b1;
          cnt_d = GAP_LOAD;
          st_d = fws_pkg::S_GAP;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      fws_pkg::S_GAP: begin
        if (cnt_q == 4'h0) begin
          st_d = fws_pkg::S_EVAL;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      default: begin
        pins_d.ce_n = 1'b0;
        pins_d.oe_n = 1'b0;
        cnt_d = ACC_LOAD;
        st_d = fws_pkg::S_ACCESS;
        case (step_q)
          fws_pkg::K_POLL: begin
            if (pol_match) begin
              step_d = fws_pkg::K_FINAL;
            end else if (rd_q[`FWS_BIT_TIMEOUT]) begin
              step_d = fws_pkg::K_POLL_RE;
            end
          end
          fws_pkg::K_POLL_RE: begin
            if (pol_match) begin
              step_d = fws_pkg::K_FINAL;
            end else begin
              fail_d = 1'b1;
              tmo_d = rd_q[`FWS_BIT_TIMEOUT];
            end
          end
          fws_pkg::K_TOG1, fws_pkg::K_TRE1: begin
            first_d = rd_q;
            step_d = (step_q == fws_pkg::K_TOG1) ? fws_pkg::K_TOG2 : fws_pkg::K_TRE2;
          end
          fws_pkg::K_TOG2: begin
            if (rd_q[`FWS_BIT_SECT_TGL] != first_q[`FWS_BIT_SECT_TGL]) begin
              setg_d = 1'b1;
            end
            if (rd_q[`FWS_BIT_BUSY_TGL] == first_q[`FWS_BIT_BUSY_TGL]) begin
              step_d = fws_pkg::K_FINAL;
            end else if (rd_q[`FWS_BIT_TIMEOUT]) begin
              step_d = fws_pkg::K_TRE1;
            end else begin
              step_d = fws_pkg::K_TOG1;
            end
          end
          fws_pkg::K_TRE2: begin
            if (rd_q[`FWS_BIT_BUSY_TGL] == first_q[`FWS_BIT_BUSY_TGL]) begin
              step_d = fws_pkg::K_FINAL;
            end else begin
              fail_d = 1'b1;
              tmo_d = rd_q[`FWS_BIT_TIMEOUT];
            end
          end
          // Array data from the following read
          default: begin
            data_d = rd_q;
            pass_d = 1'b1;
          end
        endcase
        if (fail_d || pass_d) begin
          pins_d.ce_n = 1'b1;
          pins_d.oe_n = 1'b1;
          busy_d = 1'b0;
          done_d = 1'b1;
          st_d = fws_pkg::S_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= fws_pkg::S_IDLE;
      step_q <= fws_pkg::K_POLL;
      pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, addr: `FWS_RST_ADDR};
      cnt_q <= 4'h0;
      rd_q <= 8'h00;
      first_q <= 8'h00;
      data_q <= 8'h00;
      {busy_q, done_q, pass_q, fail_q, setg_q, tmo_q} <= 6'b000000;
    end else begin
      st_q <= st_d;
      step_q <= step_d;
      pins_q <= pins_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      first_q <= first_d;
      data_q <= data_d;
      {busy_q, done_q, pass_q, fail_q, setg_q, tmo_q} <=
        {busy_d, done_d, pass_d, fail_d, setg_d, tmo_d};
    end
  end

  assign flash_pins = pins_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_addr_stable;
    busy_q && $past(busy_q) |-> $stable(pins_q.addr);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved while polling");

  property p_addr_loaded;
    $rose(busy_q) |-> pins_q.addr == $past(addr_q);
  endproperty
  a_addr_loaded: assert property (p_addr_loaded) else $error("poll address not loaded");

  property p_read_only_busy;
    !pins_q.oe_n |-> busy_q && !pins_q.ce_n;
  endproperty
  a_read_only_busy: assert property (p_read_only_busy) else $error("read strobe outside poll");

  property p_final_read;
    $rose(pass_q) |-> $past(step_q) == fws_pkg::K_FINAL;
  endproperty
  a_final_read: assert property (p_final_read) else $error("pass without final read");

  property p_fail_after_reread;
    $rose(fail_q) |-> $past(step_q) == fws_pkg::K_POLL_RE || $past(step_q) == fws_pkg::K_TRE2;
  endproperty
  a_fail_after_reread: assert property (p_fail_after_reread) else $error("fail without reread");

  property p_two_reads;
    $fell(pins_q.oe_n) && step_q == fws_pkg::K_TOG2 |-> $past(step_q) == fws_pkg::K_TOG1;
  endproperty
  a_two_reads: assert property (p_two_reads) else $error("toggle compare on single read");

  property p_access_len;
    $fell(pins_q.oe_n) |-> !pins_q.oe_n [*6] ##1 pins_q.oe_n;
  endproperty
  a_access_len: assert property (p_access_len) else $error("read cycle length wrong");

endmodule // fws_status_poller

// file: include/fws_regs.svh
`ifndef FWS_REGS_SVH
`define FWS_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ----------------------------------------------------------------
`define FWS_OFF_CTRL 8'h00
`define FWS_OFF_ADDR 8'h04
`define FWS_OFF_EXP 8'h08
`define FWS_OFF_STAT 8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FWS_CTRL_START 0
`define FWS_CTRL_MODE 1
`define FWS_STAT_BUSY 0
`define FWS_STAT_DONE 1
`define FWS_STAT_PASS 2
`define FWS_STAT_FAIL 3
`define FWS_STAT_SETG 4
`define FWS_STAT_TMO 5
`define FWS_STAT_RDY 6
`define FWS_STAT_DATA_LO 8
`define FWS_ADDR_W 22

// ----------------------------------------------------------------
// Status bit positions on the flash data lines
// ----------------------------------------------------------------
`define FWS_BIT_POLARITY 7
`define FWS_BIT_BUSY_TGL 6
`define FWS_BIT_TIMEOUT 5
`define FWS_BIT_SECT_TGL 2

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define FWS_RST_ADDR 22'h000000
`define FWS_RST_EXP 8'h00
`define FWS_CLK_NS 25
`define FWS_T_ACC_NS 70
`define FWS_T_GAP_NS 25
`define FWS_SYNC_CYC 2
`define FWS_ACC_CYC ((`FWS_T_ACC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_GAP_CYC ((`FWS_T_GAP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)

`endif

// file: include/fws_pkg.sv
`include "fws_regs.svh"

package fws_pkg;

  typedef enum logic [1:0] {
    S_IDLE,
    S_ACCESS,
    S_GAP,
    S_EVAL
  } fws_state_t;

  typedef enum logic [2:0] {
    K_POLL,
    K_POLL_RE,
    K_TOG1,
    K_TOG2,
    K_TRE1,
    K_TRE2,
    K_FINAL
  } fws_step_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic [`FWS_ADDR_W-1:0] addr;
  } fws_pins_t;

endpackage

// file: dv/fws_flash_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Flash write status model
// ----------------------------------------
module fws_flash_model (
  input wire logic ce_n, // Chip select, active low
  input wire logic oe_n, // Output enable, active low
  input wire logic [21:0] addr, // Read address
  output logic [7:0] dq, // Data lines
  output logic rb_oe, // Pulls ready/busy low
  output logic [21:0] last_addr, // Address of the last read
  input wire logic load, // Starts an operation
  input wire logic [1:0] op, // 0 array, 1 program, 2 erase, 3 erase suspend
  input wire logic [7:0] datum, // Programmed byte
  input wire logic fail, // Operation runs past its limit
  input wire logic [7:0] reads // Read cycles until done
);
  logic [7:0] left = 8'h00;
  logic busy_tgl = 1'b0;
  logic sect_tgl = 1'b0;
  logic [7:0] hold_q = 8'h00;
  logic [7:0] vis;
  logic busy;
  wire rd_off = ce_n | oe_n;
  // short, protected or suspended runs reuse these modes
  assign busy = (op == 2'd1 || op == 2'd2) && (left != 8'h00 || fail);
  always_comb begin
    vis = (op == 2'd2) ? 8'hFF : datum;
    if (busy || op == 2'd3) begin
      vis = 8'h00;
      vis[7] = (op == 2'd1) ? ~datum[7] : (op == 2'd3);
      vis[6] = busy_tgl;
      vis[5] = fail;
      vis[2] = sect_tgl;
    end
  end
  // Released lines show the inverse of the last byte
  assign dq = rd_off ? ~hold_q : vis;
  assign rb_oe = busy;
  always @(posedge load or posedge rd_off) begin
    if (load) begin
      left <= reads;
      busy_tgl <= 1'b0;
      sect_tgl <= 1'b0;
    end else begin
      hold_q <= vis;
      last_addr <= addr;
      if (busy) busy_tgl <= ~busy_tgl;
      if ((busy && op == 2'd2) || op == 2'd3) sect_tgl <= ~sect_tgl;
      if (left != 8'h00) left <= left - 8'h01;
    end
  end
endmodule // fws_flash_model

// file: dv/tb_top.sv
`timescale 1ns/1ps
`include "fws_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fws_pkg::fws_pins_t pins;
  logic [7:0] dq;
  logic rb_oe;
  logic [21:0] last_addr;
  logic load = 1'b0;
  logic [1:0] op = 2'd0;
  logic [7:0] datum = 8'h00;
  logic fail_in = 1'b0;
  logic [7:0] reads = 8'h00;
  int fail_count = 0;
  int comparisons = 0;
  // Pull-up on the ready/busy line
  wire rb_line = rb_oe ? 1'b0 : 1'b1;

  initial begin
    forever #12.5 pclk = ~pclk;
  end

  fws_status_poller dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_pins(pins), .flash_dq(dq), .ready_busy_n_pin(rb_line));

  fws_flash_model flash (.ce_n(pins.ce_n), .oe_n(pins.oe_n), .addr(pins.addr), .dq(dq),
    .rb_oe(rb_oe), .last_addr(last_addr), .load(load), .op(op), .datum(datum),
    .fail(fail_in), .reads(reads));

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        test_done();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  function automatic logic [7:0] final_byte(input logic [1:0] o, input logic [7:0] d);
    return (o == 2'd1) ? d : 8'hFF;
  endfunction

  function automatic logic [3:0] exp_flags(input logic f);
    return f ? 4'b1010 : 4'b0110;
  endfunction

  task automatic run_op(input logic [1:0] o, input logic m, input logic f,
                        input logic [7:0] nrd);
    logic [31:0] st;
    logic e;
    logic [7:0] d;
    logic [21:0] a;
    int n;
    d = 8'($urandom);
    a = 22'($urandom);
    n = 0;
    op <= o;
    datum <= d;
    fail_in <= f;
    reads <= nrd;
    load <= 1'b1;
    @(posedge pclk);
    load <= 1'b0;
    wr(`FWS_OFF_ADDR, {10'h000, a});
    wr(`FWS_OFF_EXP, {24'h000000, final_byte(o, d)});
    wr(`FWS_OFF_CTRL, {30'h0, m, 1'b1});
    apb(1'b0, `FWS_OFF_STAT, 32'h0, st, e);
    `CHK(st[0], 1'b1)
    `CHK(st[6], o == 2'd3)
    while (st[1] !== 1'b1) begin
      n++;
      if (n > 200) begin
        fail_count++;
        test_done();
      end
      apb(1'b0, `FWS_OFF_STAT, 32'h0, st, e);
    end
    `CHK(st[3:0], exp_flags(f))
    `CHK(st[5], f)
    `CHK(st[6], !f)
    `CHK(last_addr, a)
    if (!f && o != 2'd3) `CHK(st[15:8], final_byte(o, d))
    if (o == 2'd3 && m) `CHK(st[4], 1'b1)
    apb(1'b0, `FWS_OFF_CTRL, 32'h0, st, e);
    `CHK(st, {30'h0, m, 1'b0})
    $display("test op %0d mode %0d fail %0d reads %0d done", o, m, f, nrd);
  endtask

  initial begin
    logic [31:0] st;
    logic e;
    st = $urandom(32'hBA57703E);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `FWS_OFF_STAT, 32'h0, st, e);
    `CHK(st, 32'h00000040)
    apb(1'b0, `FWS_OFF_CTRL, 32'h0, st, e);
    `CHK(st, 32'h00000000)
    apb(1'b0, `FWS_OFF_ADDR, 32'h0, st, e);
    `CHK(st, 32'h00000000)
    apb(1'b0, `FWS_OFF_EXP, 32'h0, st, e);
    `CHK(st, 32'h00000000)
    apb(1'b0, 8'h10, 32'h0, st, e);
    `CHK(e, 1'b1)
    `CHK(st, 32'h00000000)
    $display("test reset and map done");
    for (int m = 0; m < 2; m++) begin
      for (int o = 1; o < 4; o++) begin
        run_op(2'(o), 1'(m), 1'b0, 8'h01);
        if (o < 3) run_op(2'(o), 1'(m), 1'b1, 8'h03);
      end
    end
    repeat (8) begin
      run_op(2'($urandom_range(3, 1)), 1'($urandom_range(1, 0)), 1'b0,
             8'($urandom_range(9, 1)));
    end
    test_done();
  end
endmodule // tb_top
